// File: piso_pkg.sv
// Shared constants and carrier types for the parallel-in serial-out shifter.
package piso_pkg;

  localparam int STAGES     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 4'h0;
  localparam logic [ADDR_W-1:0] PDATA_OFFSET  = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;

  // Control register field positions.
  localparam int CTRL_CLK_BIT  = 0;
  localparam int CTRL_ENN_BIT  = 1;
  localparam int CTRL_LSN_BIT  = 2;
  localparam int CTRL_SI_BIT   = 3;
  localparam int CTRL_CLRN_BIT = 4;

  // Status register field positions; stages sit in bits 7..0.
  localparam int STATUS_SOUT_BIT  = 8;
  localparam int STATUS_EMPTY_BIT = 9;
  localparam int STATUS_FULL_BIT  = 10;

  // Enable high, load select high, clear released, clock low.
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0016;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic shift_clock;
    logic clock_en_n;
    logic load_select_n;
    logic serial_in;
    logic clear_n;
  } ctrl_type;

  typedef struct packed {
    logic step;
    logic load_select_n;
    logic serial_in;
    logic clear_n;
  } shift_cmd_type;

endpackage : piso_pkg

// File: piso_fifo.sv
// Parameterised valid/ready FIFO built from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module piso_fifo
  import piso_pkg::*;
#(
  parameter int WIDTH = STAGES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_in_valid,
  output var  logic                     o_in_ready,
  input  wire logic [WIDTH-1:0]         i_in_data,
  output var  logic                     o_out_valid,
  input  wire logic                     i_out_ready,
  output var  logic [WIDTH-1:0]         o_out_data,
  output var  logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [CW-1:0]               count;
  } fifo_state_type;

  fifo_state_type cur_q;
  fifo_state_type nxt_d;
  logic           push;
  logic           pop;

  assign o_in_ready  = (cur_q.count != FULLC);
  assign o_out_valid = (cur_q.count != '0);
  assign o_out_data  = cur_q.mem[cur_q.rd];
  assign o_count     = cur_q.count;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_comb begin
    nxt_d = cur_q;
    if (push) begin
      nxt_d.mem[cur_q.wr] = i_in_data;
      nxt_d.wr = (cur_q.wr == LAST) ? '0 : cur_q.wr + 1'b1;
    end
    if (pop) begin
      nxt_d.rd = (cur_q.rd == LAST) ? '0 : cur_q.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_d.count = cur_q.count + 1'b1;
    end else if (pop && !push) begin
      nxt_d.count = cur_q.count - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cur_q.count <= FULLC)
    else $error("fifo count passed its depth");

endmodule // piso_fifo
`default_nettype wire

// File: piso_stages.sv
// The storage stages with their load, shift, hold and clear behaviour.
`timescale 1ns/1ps
`default_nettype none
module piso_stages
  import piso_pkg::*;
#(
  parameter int WIDTH = STAGES
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire shift_cmd_type    i_cmd,
  input  wire logic [WIDTH-1:0] i_parallel,
  output var  logic [WIDTH-1:0] o_stages
);
  typedef struct packed {
    logic [WIDTH-1:0] stages;
  } stage_state_type;

  stage_state_type  cur_q;
  stage_state_type  nxt_d;
  logic [WIDTH-1:0] shift_in;

  assign o_stages    = cur_q.stages;
  assign shift_in[0] = i_cmd.serial_in; // RULE4

  for (genvar g = 1; g < WIDTH; g++) begin : g_chain
    assign shift_in[g] = cur_q.stages[g-1]; // RULE5
  end

  always_comb begin
    nxt_d = cur_q; // RULE11
    if (!i_cmd.clear_n) begin
      nxt_d.stages = '0; // RULE10
    end else if (i_cmd.step) begin // RULE12
      // Stage k takes parallel input k, so the last stage shows input 7.
      nxt_d.stages = i_cmd.load_select_n ? shift_in : i_parallel; // RULE2 RULE3
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d; // RULE1
    end
  end

endmodule // piso_stages
`default_nettype wire

// File: piso_shift_register.sv
// AXI4-Lite wrapped eight-stage parallel-in serial-out shift register.
//
// How it works
// [RULE1] Eight stages, first to last, loaded in parallel or shifted, all synchronous.
// [RULE2] Load select low at an effective rising edge captures all parallel inputs.
// [RULE3] Parallel input k lands in stage k; last stage then shows input seven.
// [RULE4] Load select high at an effective edge puts serial input into first stage.
// [RULE5] On that shift edge each later stage takes its predecessor's old value.
// [RULE6] Cascading: the outside ties serial out to the next register's serial in.
// [RULE7] Effective clock is clock OR active-low enable; high enable blocks edges.
// [RULE8] Clock and enable are interchangeable; swapping them changes nothing.
// [RULE9] Outside should raise the enable only while the clock is high.
// [RULE10] Clear low forces all stages low, overriding every other input.
// [RULE11] Without clear and without an effective edge every stage holds.
// [RULE12] The gated clock becomes a one-cycle enable on the single system clock.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module piso_shift_register
  import piso_pkg::*;
(
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST,
  input  wire logic              I_AWVALID,
  output var  logic              O_AWREADY,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_WVALID,
  output var  logic              O_WREADY,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  output var  logic              O_BVALID,
  input  wire logic              I_BREADY,
  output var  logic [1:0]        O_BRESP,
  input  wire logic              I_ARVALID,
  output var  logic              O_ARREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  output var  logic              O_RVALID,
  input  wire logic              I_RREADY,
  output var  logic [DATA_W-1:0] O_RDATA,
  output var  logic [1:0]        O_RRESP,
  output var  logic              O_SERIAL_OUT
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  typedef struct packed {
    ctrl_type          ctrl;
    logic              eff_prev;
    logic              awready;
    logic              wready;
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [STAGES-1:0] par_hold;
  } top_state_type;

  top_state_type     cur_q;
  top_state_type     nxt_d;
  shift_cmd_type     cmd;
  logic [STAGES-1:0] stages;
  logic [STAGES-1:0] parallel;
  logic [STAGES-1:0] fifo_data;
  logic [CW-1:0]     fifo_count;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              eff_level;
  logic              step;
  logic              pop;
  logic              push;
  logic              write_go;
  logic              is_pdata;

  // The effective clock is a plain OR, so either input may act as clock or enable.
  assign eff_level = cur_q.ctrl.shift_clock | cur_q.ctrl.clock_en_n; // RULE7 RULE8
  assign step      = eff_level & ~cur_q.eff_prev; // RULE12

  assign cmd.step          = step;
  assign cmd.load_select_n = cur_q.ctrl.load_select_n;
  assign cmd.serial_in     = cur_q.ctrl.serial_in;
  assign cmd.clear_n       = cur_q.ctrl.clear_n;

  // An empty FIFO must not stall a load, so the last word taken is loaded again.
  assign parallel = fifo_out_valid ? fifo_data : cur_q.par_hold;
  assign pop      = step && cur_q.ctrl.clear_n && !cur_q.ctrl.load_select_n; // RULE2

  // A full FIFO holds back the response to a data-register write, which stalls the bus master.
  assign is_pdata = (cur_q.waddr == PDATA_OFFSET) && cur_q.wstrb[0];
  assign write_go = cur_q.aw_have && cur_q.w_have && !cur_q.bvalid &&
                    !(is_pdata && !fifo_in_ready);
  assign push     = write_go && is_pdata;

  assign O_AWREADY    = cur_q.awready;
  assign O_WREADY     = cur_q.wready;
  assign O_BVALID     = cur_q.bvalid;
  assign O_BRESP      = cur_q.bresp;
  assign O_ARREADY    = cur_q.arready;
  assign O_RVALID     = cur_q.rvalid;
  assign O_RDATA      = cur_q.rdata;
  assign O_RRESP      = cur_q.rresp;
  assign O_SERIAL_OUT = stages[STAGES-1]; // RULE3

  piso_fifo #(
    .WIDTH (STAGES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLOCK),
    .i_rst       (I_RST),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (cur_q.wdata[STAGES-1:0]),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_data),
    .o_count     (fifo_count)
  );

  piso_stages #(
    .WIDTH (STAGES)
  ) u_stages (
    .i_clk      (I_CLOCK),
    .i_rst      (I_RST),
    .i_cmd      (cmd),
    .i_parallel (parallel),
    .o_stages   (stages)
  );

  always_comb begin
    nxt_d          = cur_q;
    nxt_d.eff_prev = eff_level;
    if (pop && fifo_out_valid) begin
      nxt_d.par_hold = fifo_data;
    end

    // Write address and data are caught independently, in either order.
    if (I_AWVALID && cur_q.awready) begin
      nxt_d.awready = 1'b0;
      nxt_d.aw_have = 1'b1;
      nxt_d.waddr   = I_AWADDR;
    end
    if (I_WVALID && cur_q.wready) begin
      nxt_d.wready = 1'b0;
      nxt_d.w_have = 1'b1;
      nxt_d.wdata  = I_WDATA;
      nxt_d.wstrb  = I_WSTRB;
    end

    if (write_go) begin
      nxt_d.aw_have = 1'b0;
      nxt_d.w_have  = 1'b0;
      nxt_d.bvalid  = 1'b1;
      nxt_d.bresp   = RESP_OKAY;
      case (cur_q.waddr)
        CTRL_OFFSET: begin
          if (cur_q.wstrb[0]) begin
            nxt_d.ctrl.shift_clock   = cur_q.wdata[CTRL_CLK_BIT];
            nxt_d.ctrl.clock_en_n    = cur_q.wdata[CTRL_ENN_BIT];
            nxt_d.ctrl.load_select_n = cur_q.wdata[CTRL_LSN_BIT];
            nxt_d.ctrl.serial_in     = cur_q.wdata[CTRL_SI_BIT];
            nxt_d.ctrl.clear_n       = cur_q.wdata[CTRL_CLRN_BIT];
          end
        end
        PDATA_OFFSET:  nxt_d.bresp = RESP_OKAY;
        STATUS_OFFSET: nxt_d.bresp = RESP_OKAY;
        default:       nxt_d.bresp = RESP_SLVERR;
      endcase
    end

    if (cur_q.bvalid && I_BREADY) begin
      nxt_d.bvalid  = 1'b0;
      nxt_d.awready = 1'b1;
      nxt_d.wready  = 1'b1;
    end

    if (I_ARVALID && cur_q.arready) begin
      nxt_d.arready = 1'b0;
      nxt_d.rvalid  = 1'b1;
      nxt_d.rdata   = '0;
      nxt_d.rresp   = RESP_OKAY;
      case (I_ARADDR)
        CTRL_OFFSET: begin
          nxt_d.rdata[CTRL_CLK_BIT]  = cur_q.ctrl.shift_clock;
          nxt_d.rdata[CTRL_ENN_BIT]  = cur_q.ctrl.clock_en_n;
          nxt_d.rdata[CTRL_LSN_BIT]  = cur_q.ctrl.load_select_n;
          nxt_d.rdata[CTRL_SI_BIT]   = cur_q.ctrl.serial_in;
          nxt_d.rdata[CTRL_CLRN_BIT] = cur_q.ctrl.clear_n;
        end
        PDATA_OFFSET: begin
          nxt_d.rdata[CW-1:0] = fifo_count;
        end
        STATUS_OFFSET: begin
          nxt_d.rdata[STAGES-1:0]       = stages;
          nxt_d.rdata[STATUS_SOUT_BIT]  = stages[STAGES-1];
          nxt_d.rdata[STATUS_EMPTY_BIT] = ~fifo_out_valid;
          nxt_d.rdata[STATUS_FULL_BIT]  = ~fifo_in_ready;
        end
        default: nxt_d.rresp = RESP_SLVERR;
      endcase
    end

    if (cur_q.rvalid && I_RREADY) begin
      nxt_d.rvalid  = 1'b0;
      nxt_d.arready = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cur_q          <= '0;
      cur_q.ctrl     <= ctrl_type'({CTRL_RESET[CTRL_CLK_BIT], CTRL_RESET[CTRL_ENN_BIT],
                                    CTRL_RESET[CTRL_LSN_BIT], CTRL_RESET[CTRL_SI_BIT],
                                    CTRL_RESET[CTRL_CLRN_BIT]});
      // Matches the reset effective level, so leaving reset makes no edge.
      cur_q.eff_prev <= 1'b1;
      cur_q.awready  <= 1'b1;
      cur_q.wready   <= 1'b1;
      cur_q.arready  <= 1'b1;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  sequence load_step_s;
    step && cur_q.ctrl.clear_n && !cur_q.ctrl.load_select_n;
  endsequence

  sequence shift_step_s;
    step && cur_q.ctrl.clear_n && cur_q.ctrl.load_select_n;
  endsequence

  parallel_load_a: assert property ( // RULE2
    load_step_s |=> stages == $past(parallel))
    else $error("parallel load did not capture the inputs");

  last_stage_map_a: assert property ( // RULE3
    load_step_s ##1 1'b1 |-> O_SERIAL_OUT == $past(parallel[STAGES-1], 1))
    else $error("serial out does not show the last parallel input");

  serial_shift_a: assert property ( // RULE4
    shift_step_s |=> stages == {$past(stages[STAGES-2:0]), $past(cur_q.ctrl.serial_in)})
    else $error("shift did not move stages by one place");

  // Two shift edges can never fall in adjacent cycles, so the walk is checked at the far end.
  shift_train_a: assert property ( // RULE1
    shift_step_s |=> O_SERIAL_OUT == $past(stages[STAGES-2]))
    else $error("shift did not reach the last stage");

  first_stage_in_a: assert property ( // RULE4
    shift_step_s |=> stages[0] == $past(cur_q.ctrl.serial_in))
    else $error("first stage did not take the serial input");

  shift_chain_a: assert property ( // RULE5
    shift_step_s |=> stages[STAGES-1:1] == $past(stages[STAGES-2:0]))
    else $error("later stages did not take their predecessors");

  load_pop_a: assert property ( // RULE2
    load_step_s ##0 fifo_out_valid |=> cur_q.par_hold == $past(fifo_data))
    else $error("load did not take the buffer head");

  // A rise of the enable alone is a rise of the OR, so only a steady high enable blocks.
  enable_gate_a: assert property ( // RULE7
    cur_q.ctrl.clock_en_n && $past(cur_q.ctrl.clock_en_n) |-> !step)
    else $error("edge seen while the enable is high");

  swap_symmetry_a: assert property ( // RULE8
    step |-> eff_level && !$past(cur_q.ctrl.shift_clock | cur_q.ctrl.clock_en_n))
    else $error("edge not a rise of the combined clock");

  clear_force_a: assert property ( // RULE10
    !cur_q.ctrl.clear_n |=> stages == '0 && !O_SERIAL_OUT)
    else $error("clear did not force the stages low");

  clear_priority_a: assert property ( // RULE10
    !cur_q.ctrl.clear_n && step |=> stages == '0)
    else $error("an edge beat the clear");

  hold_value_a: assert property ( // RULE11
    !step && cur_q.ctrl.clear_n |=> $stable(stages))
    else $error("stages changed without an edge");

  single_clock_a: assert property ( // RULE12
    !$stable(stages) |-> $past(step) || !$past(cur_q.ctrl.clear_n))
    else $error("stages changed without enable or clear");

  // Bus side: each channel reopens only after its answer has been taken.
  sequence write_pair_s;
    cur_q.aw_have && cur_q.w_have && !cur_q.bvalid && !(is_pdata && !fifo_in_ready);
  endsequence

  sequence write_taken_s;
    O_BVALID && I_BREADY;
  endsequence

  sequence read_taken_s;
    O_RVALID && I_RREADY;
  endsequence

  write_answer_a: assert property (
    write_pair_s |=> O_BVALID)
    else $error("write response did not follow the write");

  ctrl_write_a: assert property (
    write_pair_s ##0 (cur_q.waddr == CTRL_OFFSET && cur_q.wstrb[0])
      |=> cur_q.ctrl.clear_n == $past(cur_q.wdata[CTRL_CLRN_BIT]))
    else $error("control write did not land");

  write_resp_done_a: assert property (
    write_taken_s |=> !O_BVALID && O_AWREADY && O_WREADY)
    else $error("write channel did not reopen after the response");

  write_busy_a: assert property (
    O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while a response is pending");

  write_code_a: assert property (
    O_BVALID |-> O_BRESP == RESP_OKAY || O_BRESP == RESP_SLVERR)
    else $error("write response code out of range");

  read_resp_done_a: assert property (
    read_taken_s |=> !O_RVALID && O_ARREADY)
    else $error("read channel did not reopen after the response");

  read_busy_a: assert property (
    O_RVALID |-> !O_ARREADY)
    else $error("read address taken while a read is pending");

  read_code_a: assert property (
    O_RVALID |-> O_RRESP == RESP_OKAY || O_RRESP == RESP_SLVERR)
    else $error("read response code out of range");

endmodule // piso_shift_register
`default_nettype wire

// File: cascade_sink.sv
// Model of the next register in a cascade, fed from the serial output.
`timescale 1ns/1ps
`default_nettype none
module cascade_sink (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_step,
  input  wire logic       i_serial,
  output var  logic [7:0] o_word
);
  // The bench pulses the step just before each shift, so it takes the old last stage.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_word <= 8'h00;
    end else if (i_step) begin
      o_word <= {o_word[6:0], i_serial};
    end
  end
endmodule // cascade_sink
`default_nettype wire

// File: tb.sv
// Self-checking bench for the register-driven shift register.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import piso_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        step = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, sout;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  chain_word;
  logic [7:0]  qm = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [4:0]  ctrl_m = 5'h16;
  logic [7:0]  fq[$];
  logic [31:0] seed = 32'h0000_9fe8;
  int          err_total = 0;
  int          check_count = 0;

  always #10 clk = ~clk;

  piso_shift_register dut_u (.I_CLOCK(clk), .I_RST(rst), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_SERIAL_OUT(sout));

  cascade_sink next_u (.i_clk(clk), .i_rst(rst), .i_step(step), .i_serial(sout),
    .o_word(chain_word));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] cw(logic c, logic e, logic l, logic s, logic r);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CTRL_CLK_BIT] = c;
    v[CTRL_ENN_BIT] = e;
    v[CTRL_LSN_BIT] = l;
    v[CTRL_SI_BIT] = s;
    v[CTRL_CLRN_BIT] = r;
    return v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Both channels are offered together; each valid drops once its own ready is seen.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] exp);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, exp}, "write response");
    if (n >= 100) begin
      err_total++;
      $display("BAD %0t write hang", $time);
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) begin
      err_total++;
      $display("BAD %0t read hang", $time);
    end
  endtask

  // Expected stages follow the OR of clock and enable; clear wins over any edge.
  task automatic ctl(input logic [31:0] v);
    logic rise;
    wr(CTRL_OFFSET, v, 4'h1, RESP_OKAY);
    rise = !(ctrl_m[CTRL_CLK_BIT] | ctrl_m[CTRL_ENN_BIT]) & (v[CTRL_CLK_BIT] | v[CTRL_ENN_BIT]);
    if (!v[CTRL_CLRN_BIT]) begin
      qm = 8'h00;
    end else if (rise && !v[CTRL_LSN_BIT]) begin
      if (fq.size() > 0) last = fq.pop_front();
      qm = last;
    end else if (rise) begin
      qm = {qm[6:0], v[CTRL_SI_BIT]};
    end
    ctrl_m = v[4:0];
  endtask

  task automatic tick(input logic l, input logic s);
    ctl(cw(1'b0, 1'b0, l, s, 1'b1));
    ctl(cw(1'b1, 1'b0, l, s, 1'b1));
  endtask

  task automatic stat();
    logic [31:0] d;
    logic [1:0] r;
    rd(STATUS_OFFSET, d, r);
    chk(d, {21'h0, fq.size() == 16, fq.size() == 0, qm[7], qm}, "status word");
  endtask

  task automatic push(input logic [7:0] b);
    wr(PDATA_OFFSET, {24'h0, b}, 4'h1, RESP_OKAY);
    fq.push_back(b);
  endtask

  // The whole run needs roughly a thousand cycles; this allows about twenty times that.
  initial begin
    #400_000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  b;
    logic        s;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_OFFSET, d, r);
    chk(d, CTRL_RESET, "control reset value");
    stat();
    $display("test reset done");
    repeat (4) begin
      b = 8'(rnd());
      push(b);
      tick(1'b0, 1'b0);
      stat();
      for (int k = 0; k < 8; k++) begin
        s = 1'(rnd());
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        tick(1'b1, s);
        stat();
      end
      chk({24'h0, chain_word}, {24'h0, b}, "cascaded word");
    end
    $display("test load and shift done");
    ctl(cw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    ctl(cw(1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
    ctl(cw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    stat();
    ctl(cw(1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    ctl(cw(1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
    stat();
    $display("test clock gating done");
    ctl(cw(1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
    stat();
    ctl(cw(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
    stat();
    ctl(cw(1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    stat();
    $display("test clear done");
    repeat (16) push(8'(rnd()));
    rd(PDATA_OFFSET, d, r);
    chk(d, 32'h0000_0010, "buffer count");
    stat();
    repeat (17) begin
      tick(1'b0, 1'b1);
      stat();
    end
    $display("test buffer done");
    rd(4'hC, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    wr(4'h2, 32'h0000_0000, 4'hF, RESP_SLVERR);
    wr(CTRL_OFFSET, 32'h0000_0000, 4'h0, RESP_OKAY);
    rd(CTRL_OFFSET, d, r);
    chk(d, {27'h0, ctrl_m}, "masked write ignored");
    wr(STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    stat();
    wr(PDATA_OFFSET, 32'h0000_00FF, 4'h0, RESP_OKAY);
    rd(PDATA_OFFSET, d, r);
    chk(d, 32'h0000_0000, "masked push ignored");
    $display("test bus errors done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
